// ===== design/ifm_core.sv
// Interrupt acceptance flags, address map decode and port pin control.
// Assumes interrupt source, CPU address and register port on clk; pins are async.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps

module ifm_core
  import ifm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic [RADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              irq_req,
  input  wire logic [PRIO_W-1:0] irq_prio,
  output logic                   irq_ack,
  output logic      [PRIO_W-1:0] irq_ack_prio,
  input  wire logic              swi_exec,
  input  wire logic [SWI_W-1:0]  swi_num,
  input  wire logic              stack_push,
  input  wire logic [ADDR_W-1:0] mem_addr,
  output logic                   sel_peri,
  output logic                   sel_ram,
  output logic                   sel_rom,
  output logic                   sel_vec,
  output logic                   sel_none,
  output logic                   int_enable,
  output logic                   stack_sel,
  output logic      [PRIO_W-1:0] proc_prio,
  input  wire logic [PORT_W-1:0] pin_in,
  output logic      [PORT_W-1:0] pin_out,
  output logic      [PORT_W-1:0] pin_oe,
  output logic      [PORT_W-1:0] pin_pullup
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic              ie_q;
  logic              ss_q;
  logic [PRIO_W-1:0] ppl_q;
  logic              ack_q;
  logic [PRIO_W-1:0] ack_prio_q;
  logic              pend_q;
  logic              flt_q;
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] pull_q;
  logic [PORT_W-1:0] out_q;
  logic [PORT_W-1:0] sync1_q;
  logic [PORT_W-1:0] sync2_q;
  logic [DATA_W-1:0] rdata_q;
  logic              peri_q;
  logic              ram_q;
  logic              rom_q;
  logic              vec_q;
  logic              none_q;

  logic              accept;
  logic              swi_fixed;
  logic              wr_flags;
  logic              wr_status;
  logic              in_peri;
  logic              in_ram;
  logic              in_rom;
  logic              in_vec;
  logic [DATA_W-1:0] rd_mux;

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  // Enable gate and strict priority compare; a blocked request stays pending
  assign accept    = ie_q && irq_req && (irq_prio > ppl_q);
  assign swi_fixed = swi_exec && (swi_num <= SWI_MAX);
  assign wr_flags  = reg_wr && (reg_addr == REG_FLAGS);
  assign wr_status = reg_wr && (reg_addr == REG_STATUS);

  // Acknowledge pulse, one cycle, with the priority it was taken at
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_q      <= RST_BIT;
      ack_prio_q <= RST_PRIO;
    end else begin
      ack_q <= accept;
      if (accept) begin
        ack_prio_q <= irq_prio;
      end
    end
  end

  // Enable flag; the acknowledge clear beats a software set in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ie_q <= RST_BIT;
    end else if (accept) begin
      ie_q <= 1'b0;
    end else if (wr_flags) begin
      ie_q <= reg_wdata[FLG_IE];
    end
  end

  // Stack select; hardware clears win over software writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ss_q <= RST_BIT;
    end else if (accept || swi_fixed) begin
      ss_q <= 1'b0;
    end else if (wr_flags) begin
      ss_q <= reg_wdata[FLG_SS];
    end
  end

  // Priority level rises to the accepted level so equal requests wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ppl_q <= RST_PRIO;
    end else if (accept) begin
      ppl_q <= irq_prio;
    end else if (wr_flags) begin
      ppl_q <= reg_wdata[FLG_PPL +: PRIO_W];
    end
  end

  // Pending view: a request is present but not accepted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= RST_BIT;
    end else begin
      pend_q <= irq_req && !accept;
    end
  end

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  // Vector table sits inside the ROM window and takes precedence
  assign in_peri = (mem_addr <= PERI_HI);
  assign in_ram = (mem_addr >= RAM_LO) && (mem_addr <= RAM_HI);
  assign in_vec = (mem_addr >= VEC_LO) && (mem_addr <= ROM_TOP);
  assign in_rom = (mem_addr >= ROM_LO) && (mem_addr < VEC_LO);

  // One-hot region select, registered; full 20-bit space covered
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      peri_q <= RST_BIT;
      ram_q  <= RST_BIT;
      rom_q  <= RST_BIT;
      vec_q  <= RST_BIT;
      none_q <= 1'b1;
    end else begin
      peri_q <= in_peri;
      ram_q  <= in_ram;
      rom_q  <= in_rom;
      vec_q  <= in_vec;
      none_q <= !(in_peri || in_ram || in_rom || in_vec);
    end
  end

  // Stack fault: a context save outside RAM; set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flt_q <= RST_BIT;
    end else if (stack_push && !in_ram) begin
      flt_q <= 1'b1;
    end else if (wr_status && reg_wdata[STS_FLT]) begin
      flt_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Port pins
  // ----------------------------------------------------------------
  // Two-stage synchroniser; only the second stage is read
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= RST_BYTE;
      sync2_q <= RST_BYTE;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Port control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_q  <= RST_BYTE;
      pull_q <= RST_BYTE;
      out_q  <= RST_BYTE;
    end else if (reg_wr) begin
      if (reg_addr == REG_DIR) begin
        dir_q <= reg_wdata;
      end
      if (reg_addr == REG_PULL) begin
        pull_q <= reg_wdata;
      end
      if (reg_addr == REG_OUT) begin
        out_q <= reg_wdata;
      end
    end
  end

  // Per-pin drivers; pull-up only when the pin is an input
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pin_oe[i]     <= RST_BIT;
        pin_out[i]    <= RST_BIT;
        pin_pullup[i] <= RST_BIT;
      end else begin
        pin_oe[i]     <= dir_q[i];
        pin_out[i]    <= out_q[i];
        pin_pullup[i] <= pull_q[i] && !dir_q[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Reserved flag bit reads 0; unmapped offsets read 0, nothing else happens
  always_comb begin
    rd_mux = RST_BYTE;
    case (reg_addr)
      REG_FLAGS: begin
        rd_mux[FLG_IE]             = ie_q;
        rd_mux[FLG_SS]             = ss_q;
        rd_mux[FLG_RSV]            = 1'b0;
        rd_mux[FLG_PPL +: PRIO_W]  = ppl_q;
      end
      REG_STATUS: begin
        rd_mux[STS_PEND]           = pend_q;
        rd_mux[STS_FLT]            = flt_q;
        rd_mux[STS_PRIO +: PRIO_W] = ack_prio_q;
      end
      REG_DIR:  rd_mux = dir_q;
      REG_PULL: rd_mux = pull_q;
      REG_OUT:  rd_mux = out_q;
      REG_PIN:  rd_mux = sync2_q;
      default:  rd_mux = RST_BYTE;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= RST_BYTE;
    end else begin
      rdata_q <= reg_rd ? rd_mux : RST_BYTE;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata    = rdata_q;
  assign irq_ack      = ack_q;
  assign irq_ack_prio = ack_prio_q;
  assign int_enable   = ie_q;
  assign stack_sel    = ss_q;
  assign proc_prio    = ppl_q;
  assign sel_peri     = peri_q;
  assign sel_ram      = ram_q;
  assign sel_rom      = rom_q;
  assign sel_vec      = vec_q;
  assign sel_none     = none_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Acknowledge only follows an enabled, higher-priority request
  a_ack_needs_enable: assert property (
    irq_ack |-> $past(ie_q) && $past(irq_req))
    else $error("ack without enable");

  a_ack_above_level: assert property (
    irq_ack |-> $past(irq_prio) > $past(ppl_q))
    else $error("ack at or below level");

  a_ack_clears_enable: assert property (
    irq_ack |-> !int_enable ##1 !irq_ack)
    else $error("enable not cleared on ack");

  a_blocked_stays: assert property (
    (irq_req && (irq_prio <= proc_prio)) |=> !irq_ack)
    else $error("low request acknowledged");

  a_disabled_quiet: assert property (
    !int_enable |=> !irq_ack)
    else $error("ack while disabled");

  a_swi_clears_sel: assert property (
    (swi_exec && (swi_num <= SWI_MAX)) |=> !stack_sel)
    else $error("stack select kept on swi");

  a_ack_clears_sel: assert property (
    irq_ack |-> !stack_sel)
    else $error("stack select kept on ack");

  a_level_follows_ack: assert property (
    irq_ack |-> proc_prio == irq_ack_prio)
    else $error("level not raised on ack");

  a_sfr_decode: assert property (
    (mem_addr <= PERI_HI) |=> sel_peri && !sel_ram)
    else $error("peripheral area missed");

  a_ram_decode: assert property (
    (mem_addr >= RAM_LO && mem_addr <= RAM_HI) |=> sel_ram)
    else $error("RAM area missed");

  a_vec_decode: assert property (
    (mem_addr >= VEC_LO && mem_addr <= ROM_TOP) |=> sel_vec && !sel_rom)
    else $error("vector table missed");

  a_rom_decode: assert property (
    (mem_addr >= ROM_LO && mem_addr < VEC_LO) |=> sel_rom)
    else $error("ROM area missed");

  a_map_onehot: assert property (
    $onehot({sel_peri, sel_ram, sel_rom, sel_vec, sel_none}))
    else $error("region select not one-hot");

  a_stack_fault: assert property (
    (stack_push && !(mem_addr >= RAM_LO && mem_addr <= RAM_HI)) |=> flt_q)
    else $error("stack fault not flagged");

  a_dir_to_oe: assert property (
    (reg_wr && reg_addr == REG_DIR) |=> ##1 pin_oe == $past(reg_wdata, 2))
    else $error("direction not applied");

  a_pull_inputs: assert property (
    (pin_pullup & pin_oe) == RST_BYTE)
    else $error("pull-up on output pin");

  a_rsv_reads_zero: assert property (
    (reg_rd && reg_addr == REG_FLAGS) |=> !reg_rdata[FLG_RSV])
    else $error("reserved bit not zero");

  c_ack: cover property (irq_ack);
  c_blocked: cover property (irq_req && int_enable && irq_prio <= proc_prio);
  c_swi: cover property (swi_exec && swi_num <= SWI_MAX && stack_sel);
  c_fault: cover property (stack_push && !sel_ram ##1 flt_q);

endmodule

// ===== include/ifm_pkg.sv
// Constants for the interrupt flag and address map block.
// Assumes one 125 MHz clock and an 8-bit register port with offsets below.
package ifm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 8;
  localparam int RADDR_W = 8;
  localparam int PRIO_W  = 3;
  localparam int SWI_W   = 6;
  localparam int PORT_W  = 8;

  // ----------------------------------------------------------------
  // Register offsets on the register port
  // ----------------------------------------------------------------
  localparam logic [RADDR_W-1:0] REG_FLAGS  = 8'h00;
  localparam logic [RADDR_W-1:0] REG_STATUS = 8'h02;
  localparam logic [RADDR_W-1:0] REG_DIR    = 8'h04;
  localparam logic [RADDR_W-1:0] REG_PULL   = 8'h06;
  localparam logic [RADDR_W-1:0] REG_OUT    = 8'h08;
  localparam logic [RADDR_W-1:0] REG_PIN    = 8'h0a;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLG_IE   = 0;
  localparam int FLG_SS   = 1;
  localparam int FLG_RSV  = 2;
  localparam int FLG_PPL  = 4;
  localparam int STS_PEND = 0;
  localparam int STS_FLT  = 1;
  localparam int STS_PRIO = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [PRIO_W-1:0] RST_PRIO = 3'h0;
  localparam logic              RST_BIT  = 1'b0;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PERI_LO  = 20'h00000;
  localparam logic [ADDR_W-1:0] PERI_HI  = 20'h002ff;
  localparam logic [ADDR_W-1:0] RAM_LO   = 20'h00400;
  localparam logic [ADDR_W-1:0] RAM_SIZE = 20'h00400;
  localparam logic [ADDR_W-1:0] RAM_HI   = RAM_LO + RAM_SIZE - 20'h00001;
  localparam logic [ADDR_W-1:0] ROM_TOP  = 20'h0ffff;
  localparam logic [ADDR_W-1:0] ROM_SIZE = 20'h08000;
  localparam logic [ADDR_W-1:0] ROM_LO   = ROM_TOP - ROM_SIZE + 20'h00001;
  localparam logic [ADDR_W-1:0] VEC_LO   = 20'h0ffdc;
  localparam logic [SWI_W-1:0]  SWI_MAX  = 6'h1f;

endpackage

// ===== dv/ifm_irq_src.sv
// Interrupt source model: raises one maskable request and holds it until acknowledged.
// Assumes the block's clock and reset; the request drops on the edge after the ack.
`timescale 1ns/100ps

module ifm_irq_src
  import ifm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              go,
  input  wire logic [PRIO_W-1:0] prio_set,
  input  wire logic [3:0]        lag,
  input  wire logic              irq_ack,
  output logic                   irq_req,
  output logic      [PRIO_W-1:0] irq_prio,
  output logic      [7:0]        ack_cnt
);
  // ----------------------------------------------------------------
  // Request sequencing
  // ----------------------------------------------------------------
  logic [4:0] wait_q;

  // A start is ignored while a request is up, so one request earns one ack
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q   <= 5'h00;
      irq_req  <= 1'b0;
      irq_prio <= 3'h0;
      ack_cnt  <= 8'h00;
    end else begin
      if (go && !irq_req) begin
        wait_q <= {1'b0, lag} + 5'h01;
      end else if (wait_q > 5'h01) begin
        wait_q <= wait_q - 5'h01;
      end else if (wait_q == 5'h01) begin
        wait_q   <= 5'h00;
        irq_req  <= 1'b1;
        irq_prio <= prio_set;
      end
      // Released priority shows the inverted level, never the stale level
      if (irq_ack) begin
        irq_req  <= 1'b0;
        irq_prio <= ~irq_prio;
        ack_cnt  <= ack_cnt + 8'h01;
      end
    end
  end
endmodule

// ===== dv/ifm_core_tb.sv
// Self-checking bench for the interrupt flag and address map block.
// Assumes the register port of the package and an interrupt source model on the same clock.
`timescale 1ns/100ps

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end

module ifm_core_tb;
  import ifm_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic [RADDR_W-1:0] reg_addr = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              irq_req, irq_ack;
  logic [PRIO_W-1:0] irq_prio, irq_ack_prio, proc_prio;
  logic              swi_exec = 1'b0;
  logic [SWI_W-1:0]  swi_num = 6'h00;
  logic              stack_push = 1'b0;
  logic [ADDR_W-1:0] mem_addr = 20'h00000;
  logic              sel_peri, sel_ram, sel_rom, sel_vec, sel_none;
  logic              int_enable, stack_sel;
  logic [PORT_W-1:0] pin_in = 8'h00;
  logic [PORT_W-1:0] pin_out, pin_oe, pin_pullup;
  logic              go = 1'b0;
  logic [PRIO_W-1:0] prio_set = 3'h0;
  logic [3:0]        lag = 4'h0;
  logic [7:0]        ack_cnt, rv;
  int                bad_count = 0;
  int                check_count = 0;
  // Region bounds and one-hot {peri, ram, rom, vec, none} expected one cycle later
  logic [19:0] ta [14] = '{20'h00000, 20'h002ff, 20'h00300, 20'h003ff, 20'h00400, 20'h007ff, 20'h00800,
                           20'h07fff, 20'h08000, 20'h0ffdb, 20'h0ffdc, 20'h0ffff, 20'h10000, 20'hfffff};
  logic [4:0]  te [14] = '{5'h10, 5'h10, 5'h01, 5'h01, 5'h08, 5'h08, 5'h01,
                           5'h01, 5'h04, 5'h04, 5'h02, 5'h02, 5'h01, 5'h01};

  always #4 clk = ~clk;

  ifm_core DUT (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_prio(irq_prio), .irq_ack(irq_ack),
    .irq_ack_prio(irq_ack_prio), .swi_exec(swi_exec), .swi_num(swi_num), .stack_push(stack_push),
    .mem_addr(mem_addr), .sel_peri(sel_peri), .sel_ram(sel_ram), .sel_rom(sel_rom), .sel_vec(sel_vec),
    .sel_none(sel_none), .int_enable(int_enable), .stack_sel(stack_sel), .proc_prio(proc_prio),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup));

  ifm_irq_src src (.clk(clk), .nrst(nrst), .go(go), .prio_set(prio_set), .lag(lag), .irq_ack(irq_ack),
    .irq_req(irq_req), .irq_prio(irq_prio), .ack_cnt(ack_cnt));

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Set the flags, start one request, then look for an ack within a bounded wait
  task automatic irq_run(input logic [7:0] f, input logic [2:0] p, input logic [3:0] l, input logic acc);
    logic got;
    got = 1'b0;
    wr(REG_FLAGS, f);
    go       <= 1'b1;
    prio_set <= p;
    lag      <= l;
    for (int i = 0; i < 16 && !got; i++) begin
      @(posedge clk);
      go <= 1'b0;
      #1 got = (irq_ack === 1'b1);
    end
    `CHK(got, acc)
    if (acc) begin
      `CHK(int_enable, 1'b0)
      `CHK(stack_sel, 1'b0)
      `CHK(proc_prio, p)
      `CHK(irq_ack_prio, p)
      @(posedge clk);
      #1 `CHK(irq_ack, 1'b0)
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog: fires after 20000 cycles; the whole sequence needs well under that
  initial begin
    #160000;
    bad_count++;
    results();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(REG_FLAGS, rv);
    `CHK(rv, 8'h00)
    rd(8'h0c, rv);
    `CHK(rv, 8'h00)
    // Every level round-trips; reserved bit always written 0
    for (int n = 0; n < 8; n++) begin
      wr(REG_FLAGS, {1'b0, n[2:0], 4'h2});
      rd(REG_FLAGS, rv);
      `CHK(rv & 8'h73, {1'b0, n[2:0], 4'h2})
      `CHK(proc_prio, n[2:0])
      `CHK(stack_sel, 1'b1)
    end
    // Masked, equal, accepted, slow source, lower priority then level dropped
    irq_run(8'h00, 3'h5, 4'h0, 1'b0);
    rd(REG_STATUS, rv);
    `CHK(rv & 8'h01, 8'h01)
    irq_run(8'h51, 3'h5, 4'h0, 1'b0);
    irq_run(8'h43, 3'h5, 4'h0, 1'b1);
    rd(REG_STATUS, rv);
    `CHK(rv & 8'h70, 8'h50)
    irq_run(8'h61, 3'h7, 4'h9, 1'b1);
    irq_run(8'h71, 3'h2, 4'h0, 1'b0);
    irq_run(8'h11, 3'h2, 4'h0, 1'b1);
    `CHK(ack_cnt, 8'h03)
    // Software interrupt numbers at both sides of the 31 boundary
    foreach (ta[n]) if (n < 4) begin
      wr(REG_FLAGS, 8'h03);
      swi_exec <= 1'b1;
      swi_num  <= (n < 2) ? 6'(n * 31) : 6'(32 + (n - 2) * 31);
      @(posedge clk);
      swi_exec <= 1'b0;
      @(posedge clk);
      #1 `CHK(stack_sel, (n >= 2))
      `CHK(int_enable, 1'b1)
    end
    // Region bounds only, including both ends of the peripheral area
    for (int i = 0; i < 14; i++) begin
      @(posedge clk);
      mem_addr <= ta[i];
      @(posedge clk);
      #1 `CHK({sel_peri, sel_ram, sel_rom, sel_vec, sel_none}, te[i])
    end
    // Context save into RAM is fine, outside RAM raises the fault
    @(posedge clk);
    stack_push <= 1'b1;
    mem_addr   <= 20'h00500;
    @(posedge clk);
    stack_push <= 1'b0;
    rd(REG_STATUS, rv);
    `CHK(rv & 8'h02, 8'h00)
    @(posedge clk);
    stack_push <= 1'b1;
    mem_addr   <= 20'h00200;
    @(posedge clk);
    stack_push <= 1'b0;
    rd(REG_STATUS, rv);
    `CHK(rv & 8'h02, 8'h02)
    wr(REG_STATUS, 8'h02);
    rd(REG_STATUS, rv);
    `CHK(rv & 8'h02, 8'h00)
    // Per-pin direction, pull-up only where the pin is an input
    wr(REG_DIR, 8'h0f);
    wr(REG_PULL, 8'hff);
    wr(REG_OUT, 8'ha5);
    pin_in <= 8'h3c;
    repeat (3) @(posedge clk);
    #1 `CHK(pin_oe, 8'h0f)
    `CHK(pin_pullup, 8'hf0)
    `CHK(pin_out, 8'ha5)
    rd(REG_PIN, rv);
    `CHK(rv, 8'h3c)
    results();
  end
endmodule
